// File: core/sca_pkg.sv
// Package of constants, carrier types and decode helpers for the agent bank.
package sca_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int unsigned SCA_AGENTS = 4;
  localparam int unsigned SCA_SEL_W  = 2;
  localparam int unsigned SCA_ADDR_W = 8;
  localparam int unsigned SCA_NODE_W = 16;
  localparam int unsigned SCA_OFSH_W = 16;
  localparam int unsigned SCA_1394_W = 48;

  // ----------------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  SCA_OFS_CTRL    = 8'h50;
  localparam logic [7:0]  SCA_OFS_ORB_HI  = 8'h54;
  localparam logic [7:0]  SCA_OFS_ORB_LO  = 8'h58;
  localparam logic [31:0] SCA_CTRL_RST    = 32'h0000FFFF;
  localparam logic [15:0] SCA_NODE_RST    = 16'hFFFF;
  localparam logic [31:0] SCA_CTRL_RSVD   = 32'h3FE40000;

  // ----------------------------------------------------------------------
  // Field positions of agent_select_control (bit 0 of the word is the LSB)
  // ----------------------------------------------------------------------
  localparam int unsigned SCA_SEL_LSB   = 30;
  localparam int unsigned SCA_TAGEN_BIT = 20;
  localparam int unsigned SCA_VALID_BIT = 19;
  localparam int unsigned SCA_WRSTB_BIT = 17;
  localparam int unsigned SCA_RDSTB_BIT = 16;
  localparam int unsigned SCA_NODE_LSB  = 0;

  // ----------------------------------------------------------------------
  // Transaction label and agent register layout on the 1394 side
  // ----------------------------------------------------------------------
  localparam logic [2:0]  SCA_TL_RSVD         = 3'h7;
  localparam logic [47:0] SCA_AGENT_STRIDE    = 48'h000000000020;
  localparam logic [4:0]  SCA_REG_AGENT_RESET = 5'h04;
  localparam logic [4:0]  SCA_REG_UNSOL_EN    = 5'h14;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic                  wr;
    logic                  rd;
    logic [SCA_ADDR_W-1:0] addr;
    logic [31:0]           wdata;
  } sca_bus_req_t;

  typedef struct packed {
    logic       valid;
    logic [5:0] tlabel;
  } sca_pkt_t;

  typedef struct packed {
    logic                  valid;
    logic [SCA_1394_W-1:0] addr;
  } sca_qwrite_t;

  typedef struct packed {
    logic                  valid;
    logic [SCA_SEL_W-1:0]  agent;
    logic [SCA_OFSH_W-1:0] hi;
    logic [31:0]           lo;
  } sca_orb_load_t;

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  // True when addr hits register reg_ofs inside the window of agent idx.
  function automatic logic sca_agent_hit(
    input logic [47:0] addr,
    input logic [47:0] base,
    input logic [1:0]  idx,
    input logic [4:0]  reg_ofs);
    logic [47:0] agent_addr;
    agent_addr = base + SCA_AGENT_STRIDE * {46'h0, idx};
    return addr == (agent_addr + {43'h0, reg_ofs});
  endfunction

endpackage

// File: core/sca_orb_bank.sv
// Per-agent ORB pointer storage with selector readback.
`timescale 1ns/1ps
`default_nettype none

module sca_orb_bank #(
  parameter int unsigned AGENTS = 4,
  parameter int unsigned SEL_W  = 2
) (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst_n,
  // Pointer updates from the agents
  input  wire sca_pkg::sca_orb_load_t     orb_load,
  input  wire logic [AGENTS-1:0]          agent_clr,
  // Selected readback
  input  wire logic [SEL_W-1:0]           sel,
  output logic [sca_pkg::SCA_OFSH_W-1:0]  orb_hi_sel,
  output logic [31:0]                     orb_lo_sel
);
  import sca_pkg::*;

  typedef struct packed {
    logic [AGENTS-1:0][SCA_OFSH_W-1:0] hi;
    logic [AGENTS-1:0][31:0]           lo;
  } sca_orb_state_t;

  sca_orb_state_t st_r;
  sca_orb_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < AGENTS; i++) begin
      if (orb_load.valid && orb_load.agent == SEL_W'(i)) begin
        st_nxt.hi[i] = orb_load.hi;
        st_nxt.lo[i] = orb_load.lo;
      end
      // An agent reset from the initiator outranks a low pointer update; the high pointer still loads.
      if (agent_clr[i]) begin
        st_nxt.lo[i] = '0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign orb_hi_sel = st_r.hi[sel];
  assign orb_lo_sel = st_r.lo[sel];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  for (genvar g = 0; g < AGENTS; g++) begin : g_chk
    property p_agent_clr;
      agent_clr[g] |=> st_r.lo[g] == 32'h0;
    endproperty
    a_agent_clr: assert property (p_agent_clr)
      else $error("ORB low not cleared by agent reset");
  end

  property p_orb_load;
    orb_load.valid && !agent_clr[orb_load.agent]
      |=> st_r.lo[$past(orb_load.agent)] == $past(orb_load.lo)
       && st_r.hi[$past(orb_load.agent)] == $past(orb_load.hi);
  endproperty
  a_orb_load: assert property (p_orb_load)
    else $error("ORB pointer load not stored");

endmodule

`default_nettype wire

// File: core/sca_agent_ctrl.sv
// Agent select, node ID and unsolicited-enable control for four agents.
//
// Operation
// - Control register resets to 0000FFFF; bus reset keeps unstated fields.
// - Selector picks the agent shown by both pointer readback registers.
// - Tag clear on: reserved label with selector clears unsolicited flags.
// - Tag clear off: reserved-label packets leave unsolicited flags alone.
// - Valid bit with selector marks node ID valid; zero on resets.
// - Write strobe assigns node field to selected agent, then clears itself.
// - Read strobe fetches selected agent node ID into field, then clears.
// - Node identifier field resets to FFFF and ignores bus reset.
// - High pointer register shows selected agent's high offset, low bits.
// - Low pointer register returns selected agent's full low offset.
// - Agent reset by the initiator zeroes that agent's low pointer.
// - Write to an agent's unsolicited enable register sets its flag.
// - Agent register windows sit 20h apart from the agent base.
`timescale 1ns/1ps
`default_nettype none

module sca_agent_ctrl (
  // Clock and reset
  input  wire logic                               ref_clk,
  input  wire logic                               rst_n,
  // Register port
  input  wire sca_pkg::sca_bus_req_t              bus_req,
  output logic [31:0]                             bus_rdata,
  // 1394 side events
  input  wire logic                               bus_reset,
  input  wire sca_pkg::sca_pkt_t                  tx_pkt,
  input  wire sca_pkg::sca_qwrite_t               qwrite,
  input  wire logic [sca_pkg::SCA_1394_W-1:0]     agent_base,
  input  wire sca_pkg::sca_orb_load_t             orb_load,
  // Agent state towards the agent machines
  output logic [sca_pkg::SCA_AGENTS-1:0][15:0]    agent_node_id,
  output logic [sca_pkg::SCA_AGENTS-1:0]          agent_id_valid,
  output logic [sca_pkg::SCA_AGENTS-1:0]          unsolicited_enable_flag
);
  import sca_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [SCA_SEL_W-1:0]                   agent_selector;
    logic                                   unsolicited_tag_clear_enable;
    logic                                   node_id_write_strobe;
    logic                                   node_id_read_strobe;
    logic [SCA_NODE_W-1:0]                  agent_node_identifier;
    logic [SCA_AGENTS-1:0][SCA_NODE_W-1:0]  node_ids;
    logic [SCA_AGENTS-1:0]                  id_valid;
    logic [SCA_AGENTS-1:0]                  unsol;
    logic [31:0]                            rdata;
  } sca_ctrl_t;

  sca_ctrl_t             st_r;
  sca_ctrl_t             st_nxt;
  logic                  wr_ctrl;
  logic [31:0]           ctrl_view;
  logic [SCA_AGENTS-1:0] unsol_set;
  logic [SCA_AGENTS-1:0] unsol_clr;
  logic [SCA_AGENTS-1:0] agent_clr;
  logic                  tag_match;
  logic [SCA_SEL_W-1:0]  wr_sel;
  logic [SCA_OFSH_W-1:0] orb_hi_sel;
  logic [31:0]           orb_lo_sel;

  // ----------------------------------------------------------------------
  // ORB pointer storage
  // ----------------------------------------------------------------------
  sca_orb_bank #(
    .AGENTS (SCA_AGENTS),
    .SEL_W  (SCA_SEL_W)
  ) u_orb_bank (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .orb_load   (orb_load),
    .agent_clr  (agent_clr),
    .sel        (st_r.agent_selector),
    .orb_hi_sel (orb_hi_sel),
    .orb_lo_sel (orb_lo_sel)
  );

  // ----------------------------------------------------------------------
  // 1394 address decode of each agent's window
  // ----------------------------------------------------------------------
  always_comb begin
    unsol_set = '0;
    agent_clr = '0;
    for (int i = 0; i < SCA_AGENTS; i++) begin
      unsol_set[i] = qwrite.valid && sca_agent_hit(qwrite.addr, agent_base,
                       SCA_SEL_W'(i), SCA_REG_UNSOL_EN);
      agent_clr[i] = qwrite.valid && sca_agent_hit(qwrite.addr, agent_base,
                       SCA_SEL_W'(i), SCA_REG_AGENT_RESET);
    end
  end

  // ----------------------------------------------------------------------
  // Readback view of the control register
  // ----------------------------------------------------------------------
  always_comb begin
    ctrl_view = '0;
    ctrl_view[SCA_SEL_LSB +: SCA_SEL_W]    = st_r.agent_selector;
    ctrl_view[SCA_TAGEN_BIT]   = st_r.unsolicited_tag_clear_enable;
    ctrl_view[SCA_VALID_BIT]   = st_r.id_valid[st_r.agent_selector];
    ctrl_view[SCA_WRSTB_BIT]   = st_r.node_id_write_strobe;
    ctrl_view[SCA_RDSTB_BIT]   = st_r.node_id_read_strobe;
    ctrl_view[SCA_NODE_LSB +: SCA_NODE_W]  = st_r.agent_node_identifier;
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt    = st_r;
    wr_ctrl   = bus_req.wr && (bus_req.addr == SCA_OFS_CTRL);
    wr_sel    = bus_req.wdata[SCA_SEL_LSB +: SCA_SEL_W];
    tag_match = tx_pkt.tlabel[5:3] == SCA_TL_RSVD
             && tx_pkt.tlabel[2:1] == st_r.agent_selector;
    st_nxt.rdata = '0;

    // Strobes act one cycle after the write that raised them.
    if (st_r.node_id_write_strobe) begin
      st_nxt.node_ids[st_r.agent_selector] = st_r.agent_node_identifier;
      st_nxt.node_id_write_strobe = 1'b0;
    end
    if (st_r.node_id_read_strobe && !st_r.node_id_write_strobe) begin
      st_nxt.agent_node_identifier = st_r.node_ids[st_r.agent_selector];
    end
    st_nxt.node_id_read_strobe = 1'b0;

    // Software write; bus reset does not touch these fields.
    if (wr_ctrl) begin
      st_nxt.agent_selector = wr_sel;
      st_nxt.unsolicited_tag_clear_enable =
        bus_req.wdata[SCA_TAGEN_BIT];
      st_nxt.node_id_write_strobe = bus_req.wdata[SCA_WRSTB_BIT];
      st_nxt.node_id_read_strobe  = bus_req.wdata[SCA_RDSTB_BIT];
      st_nxt.agent_node_identifier =
        bus_req.wdata[SCA_NODE_LSB +: SCA_NODE_W];
    end

    // Valid marks are lost on bus reset, which wins over a write.
    if (bus_reset) begin
      st_nxt.id_valid = '0;
    end else if (wr_ctrl && bus_req.wdata[SCA_VALID_BIT]) begin
      st_nxt.id_valid[wr_sel] = 1'b1;
    end

    // A setting write in the same cycle as a clear is never lost.
    unsol_clr = '0;
    if (bus_reset) begin
      unsol_clr = '1;
    end else if (tx_pkt.valid && tag_match
                 && st_r.unsolicited_tag_clear_enable) begin
      unsol_clr = '1;
    end
    st_nxt.unsol = (st_r.unsol & ~unsol_clr) | unsol_set;

    // Reads answer in the next cycle only; unmapped offsets read zero.
    if (bus_req.rd) begin
      if (bus_req.addr == SCA_OFS_CTRL) begin
        st_nxt.rdata = ctrl_view;
      end else if (bus_req.addr == SCA_OFS_ORB_HI) begin
        st_nxt.rdata = {{(32 - SCA_OFSH_W){1'b0}}, orb_hi_sel};
      end else if (bus_req.addr == SCA_OFS_ORB_LO) begin
        st_nxt.rdata = orb_lo_sel;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.agent_selector <= SCA_CTRL_RST[SCA_SEL_LSB +: SCA_SEL_W];
      st_r.unsolicited_tag_clear_enable <= SCA_CTRL_RST[SCA_TAGEN_BIT];
      st_r.agent_node_identifier <= SCA_NODE_RST;
      st_r.node_ids <= {SCA_AGENTS{SCA_NODE_RST}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus_rdata               = st_r.rdata;
  assign agent_node_id           = st_r.node_ids;
  assign agent_id_valid          = st_r.id_valid;
  assign unsolicited_enable_flag = st_r.unsol;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_keep_on_bus_reset;
    bus_reset && !wr_ctrl && !st_r.node_id_read_strobe
      |=> $stable(st_r.agent_selector)
      && $stable(st_r.unsolicited_tag_clear_enable)
      && $stable(st_r.agent_node_identifier);
  endproperty
  a_keep_on_bus_reset: assert property (p_keep_on_bus_reset)
    else $error("Control field changed by bus reset");

  property p_orb_lo_read;
    bus_req.rd && bus_req.addr == SCA_OFS_ORB_LO
      |=> bus_rdata == $past(orb_lo_sel) ##1 bus_rdata == 32'h0
       || $past(bus_req.rd);
  endproperty
  a_orb_lo_read: assert property (p_orb_lo_read)
    else $error("ORB low readback wrong or held too long");

  property p_tag_clear;
    tx_pkt.valid && tag_match && st_r.unsolicited_tag_clear_enable
      |=> (st_r.unsol & ~$past(unsol_set)) == '0;
  endproperty
  a_tag_clear: assert property (p_tag_clear)
    else $error("Reserved-label packet did not clear flags");

  property p_tag_keep;
    tx_pkt.valid && !st_r.unsolicited_tag_clear_enable && !bus_reset
      |=> st_r.unsol == ($past(st_r.unsol) | $past(unsol_set));
  endproperty
  a_tag_keep: assert property (p_tag_keep)
    else $error("Flags changed while tag clear disabled");

  property p_valid_reset;
    bus_reset |=> st_r.id_valid == '0 && !ctrl_view[SCA_VALID_BIT];
  endproperty
  a_valid_reset: assert property (p_valid_reset)
    else $error("Valid mark survived bus reset");

  property p_write_strobe;
    st_r.node_id_write_strobe && !wr_ctrl
      |=> !st_r.node_id_write_strobe
       && agent_node_id[$past(st_r.agent_selector)]
          == $past(st_r.agent_node_identifier);
  endproperty
  a_write_strobe: assert property (p_write_strobe)
    else $error("Node ID not assigned by write strobe");

  property p_read_strobe;
    st_r.node_id_read_strobe && !st_r.node_id_write_strobe && !wr_ctrl
      |=> st_r.agent_node_identifier
          == $past(agent_node_id[st_r.agent_selector])
       && !st_r.node_id_read_strobe;
  endproperty
  a_read_strobe: assert property (p_read_strobe)
    else $error("Read strobe did not fetch node ID");

  property p_unsol_set;
    unsol_set != '0 |=> (st_r.unsol & $past(unsol_set)) == $past(unsol_set);
  endproperty
  a_unsol_set: assert property (p_unsol_set)
    else $error("Unsolicited enable flag not set");

  property p_reserved_zero;
    bus_req.rd && bus_req.addr == SCA_OFS_CTRL
      |=> (bus_rdata & SCA_CTRL_RSVD) == 32'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved control bits read nonzero");

  property p_node_keep;
    bus_reset && !st_r.node_id_write_strobe |=> $stable(st_r.node_ids);
  endproperty
  a_node_keep: assert property (p_node_keep)
    else $error("Node IDs changed by bus reset");

  property p_orb_hi_read;
    bus_req.rd && bus_req.addr == SCA_OFS_ORB_HI
      |=> bus_rdata == {{(32 - SCA_OFSH_W){1'b0}}, $past(orb_hi_sel)};
  endproperty
  a_orb_hi_read: assert property (p_orb_hi_read)
    else $error("ORB high readback wrong");

  property p_rdata_idle;
    !bus_req.rd |=> bus_rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("Read data seen without a read");

  // Checked against the stride directly, not through the decode function.
  property p_window_step;
    qwrite.valid && qwrite.addr == agent_base + SCA_AGENT_STRIDE
                                   + SCA_1394_W'(SCA_REG_UNSOL_EN)
      |=> st_r.unsol[1];
  endproperty
  a_window_step: assert property (p_window_step)
    else $error("Agent one window not one step above the base");

  property p_sel_write;
    wr_ctrl |=> st_r.agent_selector == $past(wr_sel);
  endproperty
  a_sel_write: assert property (p_sel_write)
    else $error("Agent selector not taken from the write");

  property p_valid_set;
    wr_ctrl && bus_req.wdata[SCA_VALID_BIT] && !bus_reset
      |=> agent_id_valid[$past(wr_sel)];
  endproperty
  a_valid_set: assert property (p_valid_set)
    else $error("Valid mark not set by the write");

endmodule

`default_nettype wire

// File: testbench/tb_sca_agent_ctrl.sv
// Self-checking testbench for the agent select, node ID and flag block.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, gt) \
  begin \
    samples_checked++; \
    if ((gt) !== (ex)) begin \
      mismatches++; \
      $display("Error %s expected %h seen %h", nm, ex, gt); \
    end \
  end

module tb_sca_agent_ctrl;
  import sca_pkg::*;

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic                             ref_clk;
  logic                             rst_n;
  sca_bus_req_t                     bus_req;
  logic [31:0]                      bus_rdata;
  logic                             bus_reset;
  sca_pkt_t                         tx_pkt;
  sca_qwrite_t                      qwrite;
  logic [SCA_1394_W-1:0]            agent_base;
  sca_orb_load_t                    orb_load;
  logic [SCA_AGENTS-1:0][15:0]      agent_node_id;
  logic [SCA_AGENTS-1:0]            agent_id_valid;
  logic [SCA_AGENTS-1:0]            unsolicited_enable_flag;
  int                               mismatches;
  int                               samples_checked;
  int                               seed;
  logic [31:0]                      rv;
  logic [15:0]                      ids [4];
  logic [15:0]                      his [4];
  logic [31:0]                      los [4];
  logic [3:0]                       vexp;

  sca_agent_ctrl u_dut (
    .ref_clk                 (ref_clk),
    .rst_n                   (rst_n),
    .bus_req                 (bus_req),
    .bus_rdata               (bus_rdata),
    .bus_reset               (bus_reset),
    .tx_pkt                  (tx_pkt),
    .qwrite                  (qwrite),
    .agent_base              (agent_base),
    .orb_load                (orb_load),
    .agent_node_id           (agent_node_id),
    .agent_id_valid          (agent_id_valid),
    .unsolicited_enable_flag (unsolicited_enable_flag)
  );

  always #50 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Builds a control word; with both strobes zero it is also the readback.
  function automatic logic [31:0] cw(input logic [1:0] s, input logic en,
    input logic v, input logic ws, input logic rs, input logic [15:0] f);
    return {s, 9'h000, en, v, 1'b0, ws, rs, f};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus_req.wr    <= 1'b1;
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    @(posedge ref_clk);
    bus_req.wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    bus_req.rd   <= 1'b1;
    bus_req.addr <= a;
    @(posedge ref_clk);
    bus_req.rd   <= 1'b0;
    #1;
    rv = bus_rdata;
  endtask

  task automatic qw(input logic [47:0] a);
    @(posedge ref_clk);
    qwrite <= {1'b1, a};
    @(posedge ref_clk);
    qwrite.valid <= 1'b0;
    tick(1);
  endtask

  task automatic pkt(input logic [5:0] tl);
    @(posedge ref_clk);
    tx_pkt <= {1'b1, tl};
    @(posedge ref_clk);
    tx_pkt.valid <= 1'b0;
    tick(1);
  endtask

  task automatic stop_test;
    $display("Checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // A hang anywhere ends the run through the same report.
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    stop_test();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    bus_req = '0;
    bus_reset = 1'b0;
    tx_pkt = '0;
    qwrite = '0;
    orb_load = '0;
    mismatches = 0;
    samples_checked = 0;
    seed = 32'hE958;
    vexp = 4'h0;
    agent_base = {16'hFFFF, $random(seed) & 32'hFFFFFF00};
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(SCA_OFS_CTRL);
    `CHK("ctrl_reset", SCA_CTRL_RST, rv);
    rd(SCA_OFS_ORB_HI);
    `CHK("orb_hi_reset", 32'h00000000, rv);
    rd(SCA_OFS_ORB_LO);
    `CHK("orb_lo_reset", 32'h00000000, rv);
    rd(8'hA0);
    `CHK("unmapped", 32'h00000000, rv);
    // Two rounds so every agent's node ID is also overwritten once.
    for (int j = 0; j < 8; j++) begin
      ids[j % 4] = (j == 1) ? 16'h0000 : 16'($random(seed));
      wr(SCA_OFS_CTRL, cw(2'(j), 1'b0, 1'b0, 1'b1, 1'b0, ids[j % 4]));
      tick(2);
      `CHK("node_id", ids[j % 4], agent_node_id[j % 4]);
      rd(SCA_OFS_CTRL);
      `CHK("ctrl_wr", cw(2'(j), 1'b0, 1'b0, 1'b0, 1'b0, ids[j%4]), rv);
    end
    for (int i = 0; i < 4; i++) begin
      wr(SCA_OFS_CTRL, cw(2'(i), 1'b0, 1'b0, 1'b0, 1'b1, 16'h0000));
      tick(1);
      rd(SCA_OFS_CTRL);
      `CHK("ctrl_rd", cw(2'(i), 1'b0, 1'b0, 1'b0, 1'b0, ids[i]), rv);
    end
    for (int i = 0; i < 4; i++) begin
      wr(SCA_OFS_CTRL, cw(2'(i), 1'b0, 1'b1, 1'b0, 1'b0, ids[i]));
      tick(2);
      vexp[i] = 1'b1;
      `CHK("valid", vexp, agent_id_valid);
    end
    rd(SCA_OFS_CTRL);
    `CHK("ctrl_valid", cw(2'd3, 1'b0, 1'b1, 1'b0, 1'b0, ids[3]), rv);
    @(posedge ref_clk);
    bus_reset <= 1'b1;
    @(posedge ref_clk);
    bus_reset <= 1'b0;
    tick(2);
    `CHK("valid_busrst", 4'h0, agent_id_valid);
    `CHK("ids_busrst", {ids[3], ids[2], ids[1], ids[0]}, agent_node_id);
    rd(SCA_OFS_CTRL);
    `CHK("ctrl_busrst", cw(2'd3, 1'b0, 1'b0, 1'b0, 1'b0, ids[3]), rv);
    wr(SCA_OFS_CTRL, SCA_CTRL_RSVD | 32'h0000ABCD);
    tick(1);
    rd(SCA_OFS_CTRL);
    `CHK("ctrl_rsvd", 32'h0000ABCD, rv);
    wr(SCA_OFS_ORB_HI, 32'($random(seed)));
    rd(SCA_OFS_ORB_HI);
    `CHK("orb_hi_ro", 32'h00000000, rv);
    for (int i = 0; i < 4; i++) begin
      his[i] = 16'($random(seed));
      los[i] = 32'($random(seed));
      @(posedge ref_clk);
      orb_load <= {1'b1, 2'(i), his[i], los[i]};
      @(posedge ref_clk);
      orb_load.valid <= 1'b0;
    end
    // Selector walks down so each read follows a selector change.
    for (int i = 3; i >= 0; i--) begin
      wr(SCA_OFS_CTRL, cw(2'(i), 1'b0, 1'b0, 1'b0, 1'b0, 16'hABCD));
      rd(SCA_OFS_ORB_HI);
      `CHK("orb_hi", {16'h0000, his[i]}, rv);
      rd(SCA_OFS_ORB_LO);
      `CHK("orb_lo", los[i], rv);
    end
    qw(agent_base + 48'h000000000044);
    wr(SCA_OFS_CTRL, cw(2'd2, 1'b0, 1'b0, 1'b0, 1'b0, 16'hABCD));
    rd(SCA_OFS_ORB_LO);
    `CHK("orb_lo_agent_rst", 32'h00000000, rv);
    rd(SCA_OFS_ORB_HI);
    `CHK("orb_hi_agent_rst", {16'h0000, his[2]}, rv);
    for (int i = 0; i < 4; i++) begin
      qw(agent_base + 48'(i) * 48'h20 + 48'h14);
      vexp = 4'((1 << (i + 1)) - 1);
      `CHK("flag_set", vexp, unsolicited_enable_flag);
    end
    pkt({3'b111, 2'd2, 1'($random(seed))});
    `CHK("flag_en0", 4'hF, unsolicited_enable_flag);
    wr(SCA_OFS_CTRL, cw(2'd1, 1'b1, 1'b0, 1'b0, 1'b0, 16'hABCD));
    pkt({3'b110, 2'd1, 1'b1});
    `CHK("flag_badlabel", 4'hF, unsolicited_enable_flag);
    pkt({3'b111, 2'd2, 1'b0});
    `CHK("flag_otheragent", 4'hF, unsolicited_enable_flag);
    pkt({3'b111, 2'd1, 1'($random(seed))});
    `CHK("flag_clear", 4'h0, unsolicited_enable_flag);
    // After a bus reset software rewrites every node ID and marks it valid.
    @(posedge ref_clk);
    bus_reset <= 1'b1;
    @(posedge ref_clk);
    bus_reset <= 1'b0;
    tick(1);
    `CHK("valid_busrst2", 4'h0, agent_id_valid);
    for (int i = 0; i < 4; i++) begin
      ids[i] = 16'($random(seed));
      wr(SCA_OFS_CTRL, cw(2'(i), 1'b0, 1'b1, 1'b1, 1'b0, ids[i]));
      tick(2);
      `CHK("node_id_again", ids[i], agent_node_id[i]);
    end
    `CHK("valid_again", 4'hF, agent_id_valid);
    stop_test();
  end

endmodule

`default_nettype wire
